/* File: core/tmes_regs.svh */
/*
 * Constants for the trigger mode and error status interpreter.
 * Assumes inclusion by the package, the design modules and the bench.
 */
`ifndef TMES_REGS_SVH
`define TMES_REGS_SVH

`define TMES_OPT_W        4
`define TMES_OPT_MAX      4'h9
`define TMES_OPT_OP_LO    4'h8
`define TMES_ERR_W        13
`define TMES_ERR_ILLCMD   0
`define TMES_ERR_ILLOPT   1
`define TMES_ERR_NOREM    2
`define TMES_ERR_SELF     3
`define TMES_ERR_OVR      4
`define TMES_ERR_CCONF    5
`define TMES_ERR_CLOCK    6
`define TMES_ERR_ZCHK     7
`define TMES_ERR_CAL      8
`define TMES_ERR_EEDEF    9
`define TMES_ERR_EECAL    10
`define TMES_ERR_VCONF    11
`define TMES_ERR_VSRC     12
`define TMES_DEF_MODE     4'h0
`define TMES_CHAR_ONE     8'h31
`define TMES_CHAR_ZERO    8'h30
`define TMES_IDX_W        4
`define TMES_IDX_LAST     4'hC
`define TMES_IDX_ZERO     4'h0
`define TMES_QRY_MACHINE  4'h0
`define TMES_QRY_ERROR    4'h1

`endif

/* File: core/tmes_pkg.sv */
/*
 * Types for the trigger mode and error status interpreter.
 * Assumes the constants header sits beside it.
 */
`include "tmes_regs.svh"

package tmes_pkg;
    typedef enum logic [3:0] {
        TMES_STIM_TALK = 4'h1,
        TMES_STIM_GET  = 4'h2,
        TMES_STIM_EXEC = 4'h4,
        TMES_STIM_EXT  = 4'h8
    } tmes_stim_type;

    typedef enum logic [2:0] {
        TMES_S_IDLE = 3'h1,
        TMES_S_ARM  = 3'h2,
        TMES_S_RUN  = 3'h4
    } tmes_state_type;

    typedef enum logic [2:0] {
        TMES_O_NORMAL = 3'h1,
        TMES_O_ERROR  = 3'h2,
        TMES_O_OTHER  = 3'h4
    } tmes_out_type;

    typedef logic [`TMES_ERR_W-1:0] tmes_err_type;
endpackage

/* File: core/tmes_err_if.sv */
/*
 * Carrier between the interpreter and its error word serialiser.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`include "tmes_regs.svh"

interface tmes_err_if;
    logic [`TMES_ERR_W-1:0] flags;
    logic                   start;
    logic                   char_valid;
    logic [7:0]             char_data;
    logic                   char_last;

    modport core (output flags, output start, input char_valid, input char_data, input char_last);
    modport ser  (input flags, input start, output char_valid, output char_data, output char_last);
endinterface

/* File: core/tmes_err_ser.sv */
/*
 * Error word serialiser: one ASCII '0' or '1' per flag position.
 * Assumes the flags are held stable by the caller while sending.
 */
`timescale 1ns/1ps
`include "tmes_regs.svh"

module tmes_err_ser (
    input  wire logic  CLK_I,
    input  wire logic  RSTN_I,
    input  wire logic  CE_I,
    tmes_err_if.ser    err
);
    import tmes_pkg::*;

    logic                   busy_q;
    logic [`TMES_IDX_W-1:0] idx_q;
    logic [7:0]             char_q;
    logic                   valid_q;
    logic                   last_q;

    // Flag order matches the bit order, lowest first
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            busy_q  <= 1'b0;
            idx_q   <= `TMES_IDX_ZERO;
            char_q  <= `TMES_CHAR_ZERO;
            valid_q <= 1'b0;
            last_q  <= 1'b0;
        end else if (CE_I) begin
            valid_q <= busy_q;
            last_q  <= busy_q && (idx_q == `TMES_IDX_LAST);
            if (busy_q) begin
                char_q <= err.flags[idx_q] ? `TMES_CHAR_ONE : `TMES_CHAR_ZERO;
                if (idx_q == `TMES_IDX_LAST) begin
                    busy_q <= 1'b0;
                end else begin
                    idx_q <= idx_q + 1'b1;
                end
            end else if (err.start) begin
                busy_q <= 1'b1;
                idx_q  <= `TMES_IDX_ZERO;
            end
        end
    end

    assign err.char_valid = valid_q;
    assign err.char_data  = char_q;
    assign err.char_last  = last_q;

    ser_char_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        valid_q |-> (char_q == `TMES_CHAR_ONE || char_q == `TMES_CHAR_ZERO))
        else $error("error word character not a binary digit");
endmodule

/* File: core/tmes_top.sv */
/*
 * Trigger mode selection, one-time status queries and sticky error word.
 * Assumes decoded bus events arrive as one-cycle pulses on CLK_I.
 */
`timescale 1ns/1ps
`include "tmes_regs.svh"

module tmes_top #(
    parameter bit HAS_SOURCE = 1'b1
) (
    input  wire logic                   CLK_I,
    input  wire logic                   RSTN_I,
    input  wire logic                   CE_I,
    input  wire logic                   CMD_VALID_I,
    input  wire logic                   CMD_IS_TRIG_I,
    input  wire logic                   CMD_IS_QUERY_I,
    input  wire logic                   CMD_OTHER_OPT_BAD_I,
    input  wire logic                   CMD_LETTER_BAD_I,
    input  wire logic [`TMES_OPT_W-1:0] CMD_OPT_I,
    input  wire logic                   REMOTE_I,
    input  wire logic [`TMES_OPT_W-1:0] DEF_MODE_I,
    input  wire logic                   DEV_CLEAR_I,
    input  wire logic                   TALK_I,
    input  wire logic                   GET_I,
    input  wire logic                   EXEC_I,
    input  wire logic                   EXT_TRIG_I,
    input  wire logic                   OPERATE_I,
    input  wire logic                   CONV_DONE_I,
    input  wire logic                   SELFTEST_FAIL_I,
    input  wire logic                   EE_DEF_FAIL_I,
    input  wire logic                   EE_CAL_FAIL_I,
    input  wire logic                   CAL_CONFLICT_I,
    input  wire logic                   CAL_LOCKED_I,
    input  wire logic                   CAL_ZERO_CHECK_I,
    input  wire logic                   CAL_LIMIT_I,
    input  wire logic                   SRC_RANGE_I,
    input  wire logic                   SRC_INTERLOCK_I,
    input  wire logic                   SRQ_EN_I,
    output logic [`TMES_OPT_W-1:0]      TRIG_MODE_O,
    output logic                        CONV_START_O,
    output logic                        CONV_BUSY_O,
    output tmes_pkg::tmes_out_type      OUT_SEL_O,
    output logic [`TMES_OPT_W-1:0]      OUT_QUERY_O,
    output logic                        ERR_VALID_O,
    output logic [7:0]                  ERR_CHAR_O,
    output logic                        ERR_LAST_O,
    output tmes_pkg::tmes_err_type      ERR_FLAGS_O,
    output logic                        POLL_ERR_O,
    output logic                        SRQ_O
);
    import tmes_pkg::*;

    tmes_err_if err_bus ();

    logic [`TMES_OPT_W-1:0] mode_q;
    tmes_state_type         state_q;
    logic                   start_q;
    tmes_err_type           err_q;
    tmes_err_type           err_set;
    logic                   pend_q;
    logic [`TMES_OPT_W-1:0] query_q;
    tmes_out_type           out_q;
    logic                   reading_q;
    logic                   srq_armed_q;
    logic                   srq_q;
    logic                   poll_q;

    // Stimulus class of a trigger option; pairs share a class
    function automatic logic [2:0] stim_of(input logic [`TMES_OPT_W-1:0] m);
        stim_of = m[3:1];
    endfunction

    function automatic logic opt_legal(input logic [`TMES_OPT_W-1:0] m);
        opt_legal = (m <= `TMES_OPT_MAX) && (HAS_SOURCE || m < `TMES_OPT_OP_LO);
    endfunction

    logic prog_ok;
    logic trig_cmd_ok;
    logic qry_cmd_ok;
    logic stim;
    logic op_q;
    logic op_rise;
    logic err_read;

    assign prog_ok     = CMD_VALID_I && REMOTE_I && !CMD_LETTER_BAD_I;
    assign trig_cmd_ok = prog_ok && CMD_IS_TRIG_I && opt_legal(CMD_OPT_I);
    assign qry_cmd_ok  = prog_ok && CMD_IS_QUERY_I && CMD_OPT_I <= `TMES_OPT_MAX;
    assign op_rise     = OPERATE_I && !op_q;

    // Stimulus selected by the option pair
    always_comb begin
        case (stim_of(mode_q))
            3'h0:    stim = TALK_I;
            3'h1:    stim = GET_I;
            3'h2:    stim = EXEC_I;
            3'h3:    stim = EXT_TRIG_I;
            3'h4:    stim = HAS_SOURCE && op_rise;
            default: stim = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            op_q <= 1'b0;
        end else if (CE_I) begin
            op_q <= OPERATE_I;
        end
    end

    // Mode register; default loaded on clear. Reset loads a constant,
    // saved default is picked up by the first clear after release
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mode_q <= `TMES_DEF_MODE;
        end else if (CE_I) begin
            if (DEV_CLEAR_I) begin
                mode_q <= opt_legal(DEF_MODE_I) ? DEF_MODE_I : `TMES_DEF_MODE;
            end else if (trig_cmd_ok) begin
                mode_q <= CMD_OPT_I;
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_q   <= TMES_S_IDLE;
            start_q   <= 1'b0;
            reading_q <= 1'b0;
        end else if (CE_I) begin
            start_q <= 1'b0;
            if (DEV_CLEAR_I || trig_cmd_ok) begin
                state_q <= TMES_S_IDLE;
            end else begin
                case (state_q)
                    TMES_S_IDLE: begin
                        if (stim && !reading_q) begin
                            start_q <= 1'b1;
                            state_q <= mode_q[0] ? TMES_S_IDLE : TMES_S_RUN;
                        end
                    end
                    TMES_S_RUN: begin
                        if (!reading_q && !start_q) begin
                            start_q <= 1'b1;
                        end
                    end
                    default: state_q <= TMES_S_IDLE;
                endcase
            end
            if (start_q) begin
                reading_q <= 1'b1;
            end else if (CONV_DONE_I) begin
                reading_q <= 1'b0;
            end
        end
    end

    // Query latch, served once at the next talk
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pend_q  <= 1'b0;
            query_q <= `TMES_QRY_MACHINE;
            out_q   <= TMES_O_NORMAL;
        end else if (CE_I) begin
            if (DEV_CLEAR_I) begin
                pend_q <= 1'b0;
                out_q  <= TMES_O_NORMAL;
            end else if (qry_cmd_ok) begin
                pend_q  <= 1'b1;
                query_q <= CMD_OPT_I;
            end else if (TALK_I) begin
                pend_q <= 1'b0;
                if (!pend_q) begin
                    out_q <= TMES_O_NORMAL;
                end else if (query_q == `TMES_QRY_ERROR) begin
                    out_q <= TMES_O_ERROR;
                end else begin
                    out_q <= TMES_O_OTHER;
                end
            end
        end
    end

    assign err_read = CE_I && TALK_I && pend_q && !qry_cmd_ok && !DEV_CLEAR_I && query_q == `TMES_QRY_ERROR;

    // Error sources; a persisting cause keeps setting its flag
    always_comb begin
        err_set = '0;
        err_set[`TMES_ERR_ILLCMD] = CMD_VALID_I && CMD_LETTER_BAD_I;
        err_set[`TMES_ERR_ILLOPT] = CMD_VALID_I && REMOTE_I && !CMD_LETTER_BAD_I
                                   && ((CMD_IS_TRIG_I && !opt_legal(CMD_OPT_I))
                                   || (CMD_IS_QUERY_I && CMD_OPT_I > `TMES_OPT_MAX)
                                   || CMD_OTHER_OPT_BAD_I);
        err_set[`TMES_ERR_NOREM] = CMD_VALID_I && !REMOTE_I;
        err_set[`TMES_ERR_SELF]  = SELFTEST_FAIL_I;
        err_set[`TMES_ERR_OVR]   = stim && reading_q;
        err_set[`TMES_ERR_CCONF] = CAL_CONFLICT_I;
        err_set[`TMES_ERR_CLOCK] = CAL_LOCKED_I;
        err_set[`TMES_ERR_ZCHK]  = CAL_ZERO_CHECK_I;
        err_set[`TMES_ERR_CAL]   = CAL_LIMIT_I;
        err_set[`TMES_ERR_EEDEF] = EE_DEF_FAIL_I;
        err_set[`TMES_ERR_EECAL] = EE_CAL_FAIL_I;
        err_set[`TMES_ERR_VCONF] = HAS_SOURCE && SRC_RANGE_I;
        err_set[`TMES_ERR_VSRC]  = HAS_SOURCE && SRC_INTERLOCK_I && OPERATE_I;
    end

    // Sticky flags; a set in the read cycle wins over the clear
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            err_q <= '0;
        end else if (CE_I) begin
            err_q <= (err_read ? '0 : err_q) | err_set;
        end
    end

    // Poll bit and service request, re-armed by reading the word
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            poll_q      <= 1'b0;
            srq_q       <= 1'b0;
            srq_armed_q <= 1'b1;
        end else if (CE_I) begin
            poll_q <= (err_read ? 1'b0 : poll_q) | (|err_set);
            if (err_read) begin
                srq_q       <= 1'b0;
                srq_armed_q <= 1'b1;
            end
            // Set beats the clear of a read in the same cycle
            if (|err_set && (srq_armed_q || err_read) && SRQ_EN_I) begin
                srq_q       <= 1'b1;
                srq_armed_q <= 1'b0;
            end
        end
    end

    // Snapshot sent is the word before the clear
    tmes_err_type snap_q;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            snap_q <= '0;
        end else if (CE_I && err_read) begin
            snap_q <= err_q;
        end
    end

    logic start_ser_q;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            start_ser_q <= 1'b0;
        end else if (CE_I) begin
            start_ser_q <= err_read;
        end
    end

    assign err_bus.flags = snap_q;
    assign err_bus.start = start_ser_q;

    tmes_err_ser u_ser (
        .CLK_I  (CLK_I),
        .RSTN_I (RSTN_I),
        .CE_I   (CE_I),
        .err    (err_bus)
    );

    assign TRIG_MODE_O  = mode_q;
    assign CONV_START_O = start_q;
    assign CONV_BUSY_O  = reading_q;
    assign OUT_SEL_O    = out_q;
    assign OUT_QUERY_O  = query_q;
    assign ERR_VALID_O  = err_bus.char_valid;
    assign ERR_CHAR_O   = err_bus.char_data;
    assign ERR_LAST_O   = err_bus.char_last;
    assign ERR_FLAGS_O  = err_q;
    assign POLL_ERR_O   = poll_q;
    assign SRQ_O        = srq_q;

    // Assertions
    mode_legal_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && CMD_VALID_I && REMOTE_I && CMD_IS_TRIG_I && !CMD_LETTER_BAD_I && !DEV_CLEAR_I
        && opt_legal(CMD_OPT_I) |=> mode_q == $past(CMD_OPT_I))
        else $error("trigger option not taken");
    oneshot_single_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && start_q && mode_q[0] && !stim |=> !start_q)
        else $error("one-shot started twice");
    talk_trig_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && stim_of(mode_q) == 3'h0 && TALK_I && !reading_q && state_q == TMES_S_IDLE
        && !DEV_CLEAR_I && !trig_cmd_ok |=> start_q)
        else $error("talk did not trigger");
    get_trig_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && stim_of(mode_q) == 3'h1 && GET_I && !reading_q && state_q == TMES_S_IDLE
        && !DEV_CLEAR_I && !trig_cmd_ok |=> start_q)
        else $error("GET did not trigger");
    exec_trig_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && stim_of(mode_q) == 3'h2 && EXEC_I && !reading_q && state_q == TMES_S_IDLE
        && !DEV_CLEAR_I && !trig_cmd_ok |=> start_q)
        else $error("execute did not trigger");
    ext_trig_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && stim_of(mode_q) == 3'h3 && EXT_TRIG_I && !reading_q && state_q == TMES_S_IDLE
        && !DEV_CLEAR_I && !trig_cmd_ok |=> start_q)
        else $error("external did not trigger");
    op_trig_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && HAS_SOURCE && stim_of(mode_q) == 3'h4 && op_rise && !reading_q
        && state_q == TMES_S_IDLE && !DEV_CLEAR_I && !trig_cmd_ok |=> start_q)
        else $error("operate did not trigger");
    nosrc_opt_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        !HAS_SOURCE |-> mode_q < `TMES_OPT_OP_LO && !err_q[`TMES_ERR_VCONF] && !err_q[`TMES_ERR_VSRC])
        else $error("source option or flag without source");
    clear_mode_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && DEV_CLEAR_I && opt_legal(DEF_MODE_I) |=> mode_q == $past(DEF_MODE_I))
        else $error("default mode not restored");
    query_once_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && TALK_I && pend_q && !qry_cmd_ok && !DEV_CLEAR_I ##1 CE_I && TALK_I
        && !qry_cmd_ok && !DEV_CLEAR_I |=> out_q == TMES_O_NORMAL)
        else $error("query answered twice");
    err_stream_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        err_read && CE_I |-> ##3 (err_bus.char_valid || !CE_I))
        else $error("error word not sent");
    poll_set_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && |err_set |=> poll_q && err_q != '0)
        else $error("error did not set poll bit");
    read_clear_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        err_read && err_set == '0 |=> err_q == '0 && !poll_q && srq_armed_q)
        else $error("read did not clear flags");
    local_flag_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && CMD_VALID_I && !REMOTE_I && !DEV_CLEAR_I |=> err_q[`TMES_ERR_NOREM] && $stable(mode_q))
        else $error("local command not flagged");
    fault_flag_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && (SELFTEST_FAIL_I || EE_DEF_FAIL_I || EE_CAL_FAIL_I || CAL_LOCKED_I)
        |=> err_q[`TMES_ERR_SELF] || err_q[`TMES_ERR_EEDEF] || err_q[`TMES_ERR_EECAL] || err_q[`TMES_ERR_CLOCK])
        else $error("fault not flagged");
    overrun_drop_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && stim && reading_q |=> err_q[`TMES_ERR_OVR] && !start_q)
        else $error("overrun not flagged or not discarded");

    mult_run_c: cover property (@(posedge CLK_I) disable iff (!RSTN_I) state_q == TMES_S_RUN ##1 start_q);
    overrun_c: cover property (@(posedge CLK_I) disable iff (!RSTN_I) err_set[`TMES_ERR_OVR]);
    err_read_c: cover property (@(posedge CLK_I) disable iff (!RSTN_I) err_read ##[1:20] err_bus.char_last);
endmodule

/* File: sim/tmes_ctl_model.sv */
/*
 * Bus controller model: parsed commands, talk addressing, GET and device clear.
 * Assumes its tasks are called one at a time from the bench's main sequence.
 */
`timescale 1ns/1ps

module tmes_ctl_model (
    input  wire logic       clk_i,
    output logic            cmd_valid_o,
    output logic            is_trig_o,
    output logic            is_query_o,
    output logic            opt_bad_o,
    output logic            letter_bad_o,
    output logic [3:0]      opt_o,
    output logic            talk_o,
    output logic            get_o,
    output logic            clear_o
);
    initial begin
        {cmd_valid_o, is_trig_o, is_query_o, opt_bad_o, letter_bad_o, talk_o, get_o, clear_o} = '0;
        opt_o = 4'hF;
    end

    // Kind bits: letter bad, option bad, query, trigger
    task automatic cmd(input logic [3:0] kind, input logic [3:0] opt);
        @(posedge clk_i);
        {letter_bad_o, opt_bad_o, is_query_o, is_trig_o} <= kind;
        opt_o <= opt;
        cmd_valid_o <= 1'b1;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        {letter_bad_o, opt_bad_o, is_query_o, is_trig_o} <= ~kind;
        opt_o <= ~opt;
    endtask

    // 0 talk addressing, 1 GET, 2 DCL or SDC
    task automatic bus(input int k);
        @(posedge clk_i);
        talk_o <= (k == 0);
        get_o <= (k == 1);
        clear_o <= (k == 2);
        @(posedge clk_i);
        {talk_o, get_o, clear_o} <= '0;
    endtask
endmodule

/* File: sim/trigger_mode_and_error_status_tb.sv */
/*
 * Self-checking bench for the trigger mode and error status interpreter.
 * Assumes the source variant; the bench stands in for the converter.
 */
`timescale 1ns/1ps
`include "tmes_regs.svh"

module trigger_mode_and_error_status_tb;
    import tmes_pkg::*;
    logic CLK_I, RSTN_I, REMOTE_I, EXEC_I, EXT_TRIG_I, OPERATE_I, CONV_DONE_I, CE_I, SRQ_EN_I;
    logic [8:0] cause;
    logic CMD_VALID_I, CMD_IS_TRIG_I, CMD_IS_QUERY_I, CMD_OTHER_OPT_BAD_I, CMD_LETTER_BAD_I, TALK_I, GET_I;
    logic DEV_CLEAR_I, CONV_START_O, CONV_BUSY_O, ERR_VALID_O, ERR_LAST_O, POLL_ERR_O, SRQ_O;
    logic [3:0] CMD_OPT_I, TRIG_MODE_O, OUT_QUERY_O, DEF_MODE_I, TRIG_MODE_N;
    logic [7:0] ERR_CHAR_O;
    tmes_out_type OUT_SEL_O;
    tmes_err_type ERR_FLAGS_O, ERR_FLAGS_N;
    int num_errors = 0, num_checks = 0, nstart = 0, dc = 0, n0;

    tmes_top #(.HAS_SOURCE(1'b1)) DUT (.CLK_I, .RSTN_I, .CE_I, .CMD_VALID_I, .CMD_IS_TRIG_I,
        .CMD_IS_QUERY_I, .CMD_OTHER_OPT_BAD_I, .CMD_LETTER_BAD_I, .CMD_OPT_I, .REMOTE_I, .DEF_MODE_I,
        .DEV_CLEAR_I, .TALK_I, .GET_I, .EXEC_I, .EXT_TRIG_I, .OPERATE_I, .CONV_DONE_I,
        .SELFTEST_FAIL_I(cause[0]), .EE_DEF_FAIL_I(cause[1]), .EE_CAL_FAIL_I(cause[2]),
        .CAL_CONFLICT_I(cause[3]), .CAL_LOCKED_I(cause[4]), .CAL_ZERO_CHECK_I(cause[5]),
        .CAL_LIMIT_I(cause[6]), .SRC_RANGE_I(cause[7]), .SRC_INTERLOCK_I(cause[8]), .SRQ_EN_I,
        .TRIG_MODE_O, .CONV_START_O, .CONV_BUSY_O, .OUT_SEL_O, .OUT_QUERY_O, .ERR_VALID_O,
        .ERR_CHAR_O, .ERR_LAST_O, .ERR_FLAGS_O, .POLL_ERR_O, .SRQ_O);

    // No-source variant on the same stimulus; only its refusals are judged
    tmes_top #(.HAS_SOURCE(1'b0)) DUT_NS (.CLK_I, .RSTN_I, .CE_I, .CMD_VALID_I, .CMD_IS_TRIG_I,
        .CMD_IS_QUERY_I, .CMD_OTHER_OPT_BAD_I, .CMD_LETTER_BAD_I, .CMD_OPT_I, .REMOTE_I, .DEF_MODE_I,
        .DEV_CLEAR_I, .TALK_I, .GET_I, .EXEC_I, .EXT_TRIG_I, .OPERATE_I, .CONV_DONE_I,
        .SELFTEST_FAIL_I(cause[0]), .EE_DEF_FAIL_I(cause[1]), .EE_CAL_FAIL_I(cause[2]),
        .CAL_CONFLICT_I(cause[3]), .CAL_LOCKED_I(cause[4]), .CAL_ZERO_CHECK_I(cause[5]),
        .CAL_LIMIT_I(cause[6]), .SRC_RANGE_I(cause[7]), .SRC_INTERLOCK_I(cause[8]), .SRQ_EN_I,
        .TRIG_MODE_O(TRIG_MODE_N), .CONV_START_O(), .CONV_BUSY_O(), .OUT_SEL_O(), .OUT_QUERY_O(),
        .ERR_VALID_O(), .ERR_CHAR_O(), .ERR_LAST_O(), .ERR_FLAGS_O(ERR_FLAGS_N), .POLL_ERR_O(), .SRQ_O());

    tmes_ctl_model ctl (.clk_i(CLK_I), .cmd_valid_o(CMD_VALID_I), .is_trig_o(CMD_IS_TRIG_I),
        .is_query_o(CMD_IS_QUERY_I), .opt_bad_o(CMD_OTHER_OPT_BAD_I), .letter_bad_o(CMD_LETTER_BAD_I),
        .opt_o(CMD_OPT_I), .talk_o(TALK_I), .get_o(GET_I), .clear_o(DEV_CLEAR_I));

    initial begin
        CLK_I = 1'b0;
        forever #4 CLK_I = ~CLK_I;
    end

    // Converter stand-in: a reading takes five cycles
    always @(posedge CLK_I) begin
        CONV_DONE_I <= (dc == 1);
        if (CONV_START_O === 1'b1) nstart <= nstart + 1;
        dc <= (CONV_START_O === 1'b1) ? 4 : (dc > 0 ? dc - 1 : 0);
    end

    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask

    // 0 talk, 1 GET, 2 execute character, 3 external pulse, 4 operate rise
    task automatic stim(input int k);
        if (k < 2) ctl.bus(k);
        else begin
            @(posedge CLK_I);
            if (k == 4) begin
                OPERATE_I <= 1'b0;
                @(posedge CLK_I);
                OPERATE_I <= 1'b1;
            end
            EXEC_I <= (k == 2);
            EXT_TRIG_I <= (k == 3);
            @(posedge CLK_I);
            {EXEC_I, EXT_TRIG_I} <= 2'b00;
        end
    endtask

    // One-shot modes: the next pair's stimulus is ignored, their own gives one reading each
    task automatic t_pairs;
        for (int i = 0; i < 5; i++) begin
            ctl.cmd(4'h1, 4'(2 * i + 1));
            wt(2);
            chk(TRIG_MODE_O === 4'(2 * i + 1), "mode not taken");
            n0 = nstart;
            stim((i + 1) % 5);
            wt(8);
            chk(nstart == n0, "wrong stimulus started");
            stim(i);
            wt(14);
            chk(nstart == n0 + 1, "one-shot count");
        end
        chk(TRIG_MODE_N === 4'h7 && ERR_FLAGS_N[1] === 1'b1, "source option taken");
    endtask

    // Multiple mode runs on, device clear restores the default
    task automatic t_multi;
        ctl.cmd(4'h1, 4'h0);
        n0 = nstart;
        ctl.bus(0);
        wt(30);
        chk(nstart >= n0 + 3, "series did not run");
        ctl.bus(2);
        wt(10);
        chk(TRIG_MODE_O === 4'h3, "default not restored");
        n0 = nstart;
        wt(20);
        chk(nstart == n0, "series kept running");
    endtask

    task automatic t_overrun;
        n0 = nstart;
        ctl.bus(1);
        ctl.bus(1);
        wt(10);
        chk(nstart == n0 + 1, "overrun trigger started");
        chk(ERR_FLAGS_O === 13'h0010 && POLL_ERR_O === 1'b1 && SRQ_O === 1'b1, "overrun flags");
    endtask

    task automatic t_cmd_err;
        REMOTE_I <= 1'b0;
        ctl.cmd(4'h1, 4'h5);
        REMOTE_I <= 1'b1;
        ctl.cmd(4'h8, 4'h0);
        ctl.cmd(4'h1, 4'hA);
        ctl.cmd(4'h4, 4'h3);
        CE_I <= 1'b0;
        ctl.cmd(4'h1, 4'h5);
        CE_I <= 1'b1;
        wt(3);
        chk(ERR_FLAGS_O === 13'h0017 && TRIG_MODE_O === 4'h3, "command errors");
    endtask

    task automatic t_read(input logic [12:0] exp);
        int w;
        w = 0;
        ctl.cmd(4'h2, `TMES_QRY_ERROR);
        ctl.bus(0);
        #1;
        while (ERR_VALID_O !== 1'b1 && w < 10) begin
            wt(1);
            w++;
        end
        chk(OUT_SEL_O === TMES_O_ERROR, "error word not selected");
        for (int i = 0; i < 13; i++) begin
            chk(ERR_VALID_O === 1'b1 && ERR_LAST_O === (i == 12), "char framing");
            chk(ERR_CHAR_O === (exp[i] ? `TMES_CHAR_ONE : `TMES_CHAR_ZERO), "char value");
            wt(1);
        end
        chk(ERR_FLAGS_O === '0 && POLL_ERR_O === 1'b0 && SRQ_O === 1'b0, "read did not clear");
    endtask

    task automatic t_causes;
        int bits[9] = '{3, 9, 10, 5, 6, 7, 8, 11, 12};
        SRQ_EN_I <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            @(posedge CLK_I);
            cause <= 9'(1 << i);
            @(posedge CLK_I);
            cause <= '0;
            wt(2);
            chk(ERR_FLAGS_O[bits[i]] === 1'b1 && POLL_ERR_O === 1'b1, "cause flag");
        end
        chk(SRQ_O === 1'b0 && ERR_FLAGS_N[12:11] === 2'b00, "request or source flag");
        SRQ_EN_I <= 1'b1;
    endtask

    task automatic t_query;
        ctl.cmd(4'h2, `TMES_QRY_MACHINE);
        ctl.bus(0);
        wt(2);
        chk(OUT_SEL_O === TMES_O_OTHER && OUT_QUERY_O === 4'h0, "machine word");
        wt(10);
        ctl.bus(0);
        wt(2);
        chk(OUT_SEL_O === TMES_O_NORMAL, "query sent twice");
    endtask

    task automatic print_verdict;
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        {RSTN_I, EXEC_I, EXT_TRIG_I, OPERATE_I, cause} = '0;
        {REMOTE_I, CE_I, SRQ_EN_I} = 3'h7;
        DEF_MODE_I = 4'h3;
        repeat (5) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        wt(1);
        chk(OUT_SEL_O === TMES_O_NORMAL && ERR_FLAGS_O === '0 && TRIG_MODE_O === 4'h0, "reset state");
        t_pairs;
        t_multi;
        t_overrun;
        t_cmd_err;
        t_read(13'h0017);
        t_causes;
        t_read(13'h1FE8);
        t_query;
        print_verdict;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge CLK_I);
        num_errors++;
        print_verdict;
    end
endmodule
